// *** mtd_asserts.sv ***
/* Port checker for mtd_decoder.
   Bound to every instance; sees only its ports. */
`timescale 1ns/10ps
module mtd_asserts #(
  parameter int ONCHIP_BYTES = 4096
) (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        clk_en,
  // Register port
  input wire logic        sfr_wr,
  input wire logic        sfr_rd,
  input wire logic [7:0]  sfr_addr,
  input wire logic [7:0]  sfr_wdata,
  input wire logic [7:0]  sfr_rdata,
  // Move request
  input wire logic [1:0]  ext_mem_config,
  input wire logic [7:0]  ext_mem_page,
  input wire logic [7:0]  rx_low,
  input wire logic [15:0] data_pointer_pair,
  input wire logic        move_req,
  input wire logic        move_wide,
  input wire logic        move_write,
  input wire logic        code_read_req,
  // Decision
  input wire logic [2:0]  move_target,
  input wire logic [15:0] onchip_addr,
  input wire logic [11:0] bus_addr_oe,
  input wire logic        code_scratch
);
  logic [2:0]  psc_m;
  logic [15:0] eff;
  logic        rd;
  logic        sp;
  assign eff = move_wide ? data_pointer_pair : {ext_mem_page, rx_low};
  assign rd = move_req && clk_en && !move_write;
  assign sp = psc_m[2];
  // Shadow of the enables, so flash checks need no internal probe
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      psc_m <= 3'h0;
    else if (clk_en && sfr_wr && sfr_addr == 8'h8f)
      psc_m <= sfr_wdata[2:0];
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_split_hi;
    rd && ext_mem_config == 2'h1 ##0 eff >= ONCHIP_BYTES;
  endsequence
  a_internal_target: assert property (
    rd && ext_mem_config == 2'h0 |=> move_target == 3'h1) else $error("target");
  a_wrap_mask: assert property (
    rd && ext_mem_config == 2'h0 |=> onchip_addr == ($past(eff) & 16'(ONCHIP_BYTES - 1)))
    else $error("wrap");
  a_split_below: assert property (
    rd && ext_mem_config == 2'h1 && eff < ONCHIP_BYTES |=> move_target == 3'h1)
    else $error("below");
  a_split_above: assert property (
    s_split_hi |=> move_target == 3'h2) else $error("above");
  a_narrow_drive: assert property (
    s_split_hi ##0 !move_wide |=> bus_addr_oe == 12'h0ff) else $error("narrow");
  a_wide_drive: assert property (
    s_split_hi ##0 move_wide |=> bus_addr_oe == 12'hfff) else $error("wide");
  a_flash_prog: assert property (
    move_req && clk_en && move_write && psc_m[1:0] == 2'h1 |=> move_target == 3'h3)
    else $error("prog");
  a_page_erase: assert property (
    move_req && clk_en && move_write && psc_m[1:0] == 2'h3 |=> move_target == 3'h4)
    else $error("erase");
  a_scratch_read: assert property (
    code_read_req && clk_en |=> code_scratch == $past(sp)) else $error("scratch");
  a_ctrl_read: assert property (
    sfr_rd && clk_en && sfr_addr == 8'h8f |=> sfr_rdata == {5'h0, $past(psc_m)})
    else $error("readback");
endmodule
bind mtd_decoder mtd_asserts #(.ONCHIP_BYTES(ONCHIP_BYTES)) mtd_asserts_inst (
  .core_clk          (core_clk),
  .rst_n             (rst_n),
  .clk_en            (clk_en),
  .sfr_wr            (sfr_wr),
  .sfr_rd            (sfr_rd),
  .sfr_addr          (sfr_addr),
  .sfr_wdata         (sfr_wdata),
  .sfr_rdata         (sfr_rdata),
  .ext_mem_config    (ext_mem_config),
  .ext_mem_page      (ext_mem_page),
  .rx_low            (rx_low),
  .data_pointer_pair (data_pointer_pair),
  .move_req          (move_req),
  .move_wide         (move_wide),
  .move_write        (move_write),
  .code_read_req     (code_read_req),
  .move_target       (move_target),
  .onchip_addr       (onchip_addr),
  .bus_addr_oe       (bus_addr_oe),
  .code_scratch      (code_scratch)
);

// *** mtd_decoder.sv ***
/*
  Address-target decoder for the core's external-data move instructions.
  Routes each move in modes 00 and 01 to on-chip extended RAM, the off-chip address bus, or
  flash (write or page erase), and outputs the registered decision.
  Assumes the core presents one move request per cycle as a strobe with its
  operands, synchronous to core_clk, and keeps software flash address rules.
*/
//Behaviour
//[R01] Mode 00: every move targets on-chip extended RAM, never the bus.
//[R02] Internal-only mode wraps addresses past on-chip RAM size back to start.
//[R03] 8-bit move address: page register high byte, R0/R1 low byte.
//[R04] 16-bit move address: whole data pointer pair.
//[R05] Mode 01 splits the map into on-chip and off-chip regions.
//[R06] Split mode: addresses below the boundary go to on-chip RAM.
//[R07] Split mode: addresses above the boundary go off-chip over the bus.
//[R08] Split 8-bit off-chip: page decides, A[11:8] left undriven.
//[R09] Split 8-bit off-chip: A[7:0] driven from R0/R1.
//[R10] Split 16-bit: data pointer decides, all A[11:0] driven off-chip.
//[R11] Scratchpad select routes flash reads and move writes to scratchpad.
//[R12] Software keeps flash addresses in 0x0000-0x03FF with scratchpad on.
//[R13] Erase plus write enable: move write erases the page, data ignored.
//[R14] Write enable: move write programs flash; clear disables flash writes.
//[R15] Software erases a flash location before programming it.
//[R16] Control bits 7:3 read zero, ignore writes; enables reset zero.
//[R17] Without write enable, writes and all reads follow mode decode.
`timescale 1ns/10ps
`include "mtd_map.svh"

module mtd_decoder #(
  parameter int ONCHIP_BYTES = `MTD_ONCHIP_BYTES
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // Register port
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  // Mode and operands from the core
  input  wire logic [1:0]  ext_mem_config,
  input  wire logic [7:0]  ext_mem_page,
  input  wire logic [7:0]  rx_low,
  input  wire logic [15:0] data_pointer_pair,
  // Move request
  input  wire logic        move_req,
  input  wire logic        move_wide,
  input  wire logic        move_write,
  input  wire logic [7:0]  move_wdata,
  input  wire logic        code_read_req,
  // Decision
  output logic             move_valid,
  output logic [2:0]       move_target,
  output logic [15:0]      onchip_addr,
  output logic [11:0]      bus_addr,
  output logic [11:0]      bus_addr_oe,
  output logic [7:0]       flash_wdata,
  output logic [15:0]      flash_addr,
  output logic             flash_scratch,
  output logic             code_scratch
);

  // Wrap by masking only works for a power-of-two size
  if (ONCHIP_BYTES < 2 || ONCHIP_BYTES > 65536 || (ONCHIP_BYTES & (ONCHIP_BYTES - 1)) != 0)
  begin
    $error("ONCHIP_BYTES must be a power of two in 2..65536");
  end

  localparam logic [16:0] BOUNDARY = 17'(ONCHIP_BYTES);
  localparam logic [15:0] WRAP_MASK = 16'(ONCHIP_BYTES - 1);

  logic [7:0]  psc_value;
  logic [15:0] eff_addr;
  logic        below;
  mtd_pkg::mtd_target_t tgt_next;
  logic [15:0] onchip_next;
  logic [11:0] bus_next;
  logic [11:0] oe_next;

  mtd_psc_reg u_psc (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .sfr_wr    (sfr_wr),
    .sfr_addr  (sfr_addr),
    .sfr_wdata (sfr_wdata),
    .psc_value (psc_value)
  );

  wire logic we_bit = psc_value[`MTD_PSC_WE_BIT];
  wire logic ee_bit = psc_value[`MTD_PSC_EE_BIT];
  wire logic sp_bit = psc_value[`MTD_PSC_SP_BIT];

  // Effective address by move width
  always_comb
  begin
    if (move_wide)
      eff_addr = data_pointer_pair; // see [R04]
    else
      eff_addr = {ext_mem_page, rx_low}; // see [R03]
    below = {1'b0, eff_addr} < BOUNDARY;
  end

  // Target selection; flash paths take priority over the mode decode
  always_comb
  begin
    tgt_next    = mtd_pkg::MTD_TGT_ONCHIP;
    onchip_next = eff_addr & WRAP_MASK;
    bus_next    = 12'h000;
    oe_next     = 12'h000;
    if (move_write && we_bit)
    begin
      if (ee_bit)
        tgt_next = mtd_pkg::MTD_TGT_FLASH_ERASE; // see [R13]
      else
        tgt_next = mtd_pkg::MTD_TGT_FLASH_WRITE; // see [R14]
    end
    else
    begin
      case (ext_mem_config) // see [R17]
        `MTD_MODE_INT_ONLY:
        begin
          // Wrap keeps every address on chip
          tgt_next = mtd_pkg::MTD_TGT_ONCHIP; // see [R01] [R02]
        end
        `MTD_MODE_SPLIT:
        begin
          if (below)
          begin
            tgt_next = mtd_pkg::MTD_TGT_ONCHIP; // see [R05] [R06]
          end
          else
          begin
            tgt_next = mtd_pkg::MTD_TGT_OFFCHIP; // see [R07]
            bus_next = eff_addr[11:0];
            if (move_wide)
              oe_next = `MTD_OE_WIDE; // see [R10]
            else
              oe_next = `MTD_OE_NARROW; // see [R08] [R09]
          end
        end
        default:
        begin
          // Bank-select and off-chip-only modes are outside this block
          tgt_next = mtd_pkg::MTD_TGT_NONE;
        end
      endcase
    end
  end

  // Answer strobe, one cycle after each move
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      move_valid <= 1'b0;
    end
    else if (clk_en)
    begin
      move_valid <= move_req;
    end
  end

  // Decision and on-chip address hold until the next move
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      move_target <= 3'h0;
      onchip_addr <= 16'h0000;
    end
    else if (clk_en && move_req)
    begin
      move_target <= tgt_next;
      onchip_addr <= onchip_next;
    end
  end

  // Pins released after an idle edge, so no stale drive fights the port latches
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_addr    <= 12'h000;
      bus_addr_oe <= 12'h000;
    end
    else if (clk_en)
    begin
      if (move_req)
      begin
        bus_addr    <= bus_next;
        bus_addr_oe <= oe_next; // see [R08] [R10]
      end
      else
      begin
        bus_addr_oe <= 12'h000;
      end
    end
  end

  // Flash operands, latched on every move
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flash_wdata   <= 8'h00;
      flash_addr    <= 16'h0000;
      flash_scratch <= 1'b0;
    end
    else if (clk_en && move_req)
    begin
      flash_addr    <= eff_addr;
      // Data is meaningless for a page erase
      flash_wdata   <= ee_bit ? 8'h00 : move_wdata; // see [R13]
      flash_scratch <= sp_bit; // see [R11]
    end
  end

  // Code reads from software follow the scratchpad select too
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      code_scratch <= 1'b0;
    else if (clk_en)
      code_scratch <= code_read_req & sp_bit; // see [R11]
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      sfr_rdata <= 8'h00;
    else if (clk_en)
      sfr_rdata <= (sfr_rd && sfr_addr == `MTD_PSC_OFFSET) ? psc_value : 8'h00; // see [R16]
  end

endmodule

// *** mtd_ext_ram.sv ***
/* Far-side memory: resolves the address pins it sees.
   Undriven pins show the port latch level, not the last value. */
`timescale 1ns/10ps
module mtd_ext_ram #(
  parameter logic [11:0] LATCH = 12'ha5a
) (
  // Address pins
  input wire logic [11:0] bus_addr,
  input wire logic [11:0] bus_addr_oe,
  output logic     [11:0] seen_addr
);
  assign seen_addr = (bus_addr & bus_addr_oe) | (LATCH & ~bus_addr_oe);
endmodule

// *** mtd_map.svh ***
/*
  Constants for the external-data move target decoder: register offset,
  field positions, mode codes and sizes.
  Assumes it is included by bare name from the package and the design files.
*/
`ifndef MTD_MAP_SVH
`define MTD_MAP_SVH

`define MTD_PSC_OFFSET      8'h8f
`define MTD_PSC_WE_BIT      0
`define MTD_PSC_EE_BIT      1
`define MTD_PSC_SP_BIT      2
`define MTD_PSC_RESET       3'h0
`define MTD_MODE_INT_ONLY   2'h0
`define MTD_MODE_SPLIT      2'h1
`define MTD_ONCHIP_BYTES    4096
`define MTD_SCRATCH_LAST    16'h03ff
`define MTD_OE_WIDE         12'hfff
`define MTD_OE_NARROW       12'h0ff

`endif

// *** mtd_pkg.sv ***
/*
  Types for the external-data move target decoder.
  Assumes mtd_map.svh is on the include path.
*/
`include "mtd_map.svh"

package mtd_pkg;

  typedef enum logic [2:0] {
    MTD_TGT_NONE,
    MTD_TGT_ONCHIP,
    MTD_TGT_OFFCHIP,
    MTD_TGT_FLASH_WRITE,
    MTD_TGT_FLASH_ERASE
  } mtd_target_t;

  typedef enum logic [1:0] {
    MTD_MODE_INTERNAL,
    MTD_MODE_SPLIT_NB,
    MTD_MODE_OTHER
  } mtd_mode_t;

endpackage

// *** mtd_psc_reg.sv ***
/*
  Program-store control register: three enable bits, upper bits read zero.
  Assumes a special-function-register style port: write strobe with offset
  and data, read data combinational from the stored bits.
*/
`timescale 1ns/10ps
`include "mtd_map.svh"

module mtd_psc_reg (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  // Register port
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] psc_value
);

  logic [2:0] bits_reg;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bits_reg <= `MTD_PSC_RESET; // see [R16]
    end
    else if (clk_en && sfr_wr && sfr_addr == `MTD_PSC_OFFSET)
    begin
      bits_reg <= sfr_wdata[2:0];
    end
  end

  // Upper bits fixed at zero, writes to them dropped
  assign psc_value = {5'h00, bits_reg}; // see [R16]

endmodule

// *** tb_ext_data_move_target_decoder.sv ***
/* Self-checking bench for mtd_decoder with the far-side memory.
   Assumes the default on-chip size of 4096 bytes. */
`timescale 1ns/10ps
module tb_ext_data_move_target_decoder;
  typedef struct packed {
    logic [1:0] cfg; logic wide; logic [15:0] ea; logic [2:0] tgt; logic [11:0] oe;
  } mtd_row_t;
  mtd_row_t rows [7] = '{
    '{2'h0, 1'b1, 16'hf234, 3'h1, 12'h0}, '{2'h0, 1'b0, 16'h1099, 3'h1, 12'h0},
    '{2'h1, 1'b1, 16'h0fff, 3'h1, 12'h0}, '{2'h1, 1'b1, 16'h1000, 3'h2, 12'hfff},
    '{2'h1, 1'b0, 16'h2034, 3'h2, 12'h0ff}, '{2'h2, 1'b1, 16'h0010, 3'h0, 12'h0},
    '{2'h1, 1'b0, 16'h0f12, 3'h1, 12'h0}};
  logic core_clk = 0, rst_n = 0, clk_en = 1, sfr_wr = 0, sfr_rd = 0, move_req = 0;
  logic move_wide = 0, move_write = 0, code_read_req = 0;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0, ext_mem_page = 0, rx_low = 0, move_wdata = 8'h5a;
  logic [1:0] ext_mem_config = 0;
  logic [15:0] data_pointer_pair = 0, onchip_addr, flash_addr;
  logic [7:0] sfr_rdata, flash_wdata;
  logic [11:0] bus_addr, bus_addr_oe, seen_addr, pin_exp;
  logic [2:0] move_target;
  logic move_valid, flash_scratch, code_scratch;
  int err_total = 0, compares = 0, cyc = 0;
  mtd_decoder mtd_decoder_inst (
    .core_clk          (core_clk),
    .rst_n             (rst_n),
    .clk_en            (clk_en),
    .sfr_wr            (sfr_wr),
    .sfr_rd            (sfr_rd),
    .sfr_addr          (sfr_addr),
    .sfr_wdata         (sfr_wdata),
    .sfr_rdata         (sfr_rdata),
    .ext_mem_config    (ext_mem_config),
    .ext_mem_page      (ext_mem_page),
    .rx_low            (rx_low),
    .data_pointer_pair (data_pointer_pair),
    .move_req          (move_req),
    .move_wide         (move_wide),
    .move_write        (move_write),
    .move_wdata        (move_wdata),
    .code_read_req     (code_read_req),
    .move_valid        (move_valid),
    .move_target       (move_target),
    .onchip_addr       (onchip_addr),
    .bus_addr          (bus_addr),
    .bus_addr_oe       (bus_addr_oe),
    .flash_wdata       (flash_wdata),
    .flash_addr        (flash_addr),
    .flash_scratch     (flash_scratch),
    .code_scratch      (code_scratch)
  );
  mtd_ext_ram mtd_ext_ram_inst (
    .bus_addr    (bus_addr),
    .bus_addr_oe (bus_addr_oe),
    .seen_addr   (seen_addr)
  );
  always #20 core_clk = ~core_clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic mv(input logic [1:0] c, input logic w, input logic wr, input logic [15:0] ea);
    @(negedge core_clk);
    {ext_mem_config, move_wide, move_write} = {c, w, wr};
    // Unused operand set apart, so a wrong address source shows up
    data_pointer_pair = w ? ea : ~ea;
    {ext_mem_page, rx_low} = w ? ~ea : ea;
    move_req = 1;
    @(negedge core_clk);
    move_req = 0;
  endtask
  task automatic sfr(input logic w, input logic [7:0] d);
    @(negedge core_clk);
    {sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = {w, !w, 8'h8f, d};
    @(negedge core_clk);
    {sfr_wr, sfr_rd} = 2'b00;
  endtask
  task results;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Ceiling well above the ~45 cycles the tests take
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 400)
    begin
      err_total++;
      results();
    end
  end
  initial
  begin
    repeat (4) @(negedge core_clk);
    rst_n = 1;
    sfr(0, 8'h0);
    chk(sfr_rdata, 8'h00);
    $display("reset value test done");
    foreach (rows[i])
    begin
      mv(rows[i].cfg, rows[i].wide, 0, rows[i].ea);
      chk(move_valid, 1'b1);
      chk(move_target, rows[i].tgt);
      pin_exp = (rows[i].ea[11:0] & rows[i].oe) | (12'ha5a & ~rows[i].oe);
      chk(seen_addr, pin_exp);
      if (rows[i].tgt == 3'h1)
        chk(onchip_addr, rows[i].ea & 16'h0fff);
      @(negedge core_clk);
      chk({move_valid, 3'h0, bus_addr_oe}, 16'h0000);
      $display("row %0d done", i);
    end
    sfr(1, 8'hff);
    sfr(0, 8'h0);
    chk(sfr_rdata, 8'h07);
    @(negedge core_clk) code_read_req = 1;
    @(negedge core_clk) code_read_req = 0;
    chk(code_scratch, 1'b1);
    mv(2'h1, 1, 1, 16'h0100);
    chk(move_target, 3'h4);
    chk(flash_wdata, 8'h00);
    chk(flash_addr, 16'h0100);
    chk(flash_scratch, 1'b1);
    sfr(1, 8'h01);
    mv(2'h1, 1, 1, 16'h0100);
    chk(move_target, 3'h3);
    chk({flash_wdata, 7'h0, flash_scratch}, 16'h5a00);
    chk(flash_addr, 16'h0100);
    $display("flash test done");
    @(negedge core_clk) rst_n = 0;
    @(negedge core_clk) rst_n = 1;
    sfr(0, 8'h0);
    chk(sfr_rdata, 8'h00);
    mv(2'h1, 1, 1, 16'h2000);
    chk(move_target, 3'h2);
    chk(bus_addr_oe, 12'hfff);
    $display("reset test done");
    results();
  end
endmodule
